// *** hdl/tuirq_defs.svh ***
/*
 * constants for the translation unit interrupt output stage.
 * assumes inclusion by bare name from any design file that needs them.
 */
`ifndef TUIRQ_DEFS_SVH
`define TUIRQ_DEFS_SVH

// -----------------------------------------------------------------
// source indices of the interrupt vector
// -----------------------------------------------------------------
`define TUIRQ_NSRC 9
`define TUIRQ_SRC_EVTQ_S 0
`define TUIRQ_SRC_EVTQ_NS 1
`define TUIRQ_SRC_SYNC_S 2
`define TUIRQ_SRC_SYNC_NS 3
`define TUIRQ_SRC_GLOB_S 4
`define TUIRQ_SRC_GLOB_NS 5
`define TUIRQ_SRC_RAS 6
`define TUIRQ_SRC_PMU 7
`define TUIRQ_SRC_PRIQ 8
// sources 0..5 may go as messages, 6..8 are wire only
`define TUIRQ_MSI_MASK 9'h03f

// -----------------------------------------------------------------
// timing: a pulse is high one cycle, then low at least one cycle
// -----------------------------------------------------------------
`define TUIRQ_PULSE_HIGH 2'h1
`define TUIRQ_PULSE_LOW 2'h1
`define TUIRQ_MSI_IDX_W 4

`endif

// *** hdl/tuirq_pkg.sv ***
/*
 * types for the translation unit interrupt output stage.
 * assumes tuirq_defs.svh is on the include path.
 */
package tuirq_pkg;
   // -----------------------------------------------------------------
   // edge generator states, gray along idle -> high -> low, both bits change on low -> idle
   // -----------------------------------------------------------------
   typedef enum logic [1:0]
   {
      TUIRQ_IDLE = 2'h0,
      TUIRQ_HIGH = 2'h1,
      TUIRQ_LOW = 2'h3
   } tuirq_edge_state_t;
endpackage : tuirq_pkg

// *** hdl/tuirq_edge.sv ***
/*
 * one interrupt edge generator: latches an event and turns it into a
 * one-cycle high pulse followed by at least one low cycle.
 * assumes events come from logic on sys_clk_in.
 */
`timescale 1ns/1ns
`include "tuirq_defs.svh"

module tuirq_edge
(
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic event_in,
   output logic irq_out
);
   import tuirq_pkg::*;

   tuirq_edge_state_t state;
   tuirq_edge_state_t next_state;
   logic pend;
   logic next_pend;
   logic irq;
   logic next_irq;

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   // (R01) event latched, one edge per occurrence
   always_comb
   begin
      next_state = state;
      next_pend = pend;
      next_irq = 1'b0;
      unique case (state)
         TUIRQ_IDLE:
         begin
            if (pend || event_in)
            begin
               next_state = TUIRQ_HIGH;
               next_irq = 1'b1;
               next_pend = 1'b0;
            end
         end
         TUIRQ_HIGH:
         begin
            next_state = TUIRQ_LOW;
            next_pend = pend | event_in;
         end
         TUIRQ_LOW:
         begin
            // (R11) low cycle before next edge
            next_state = TUIRQ_IDLE;
            next_pend = pend | event_in;
         end
         default:
         begin
            next_state = TUIRQ_IDLE;
            next_pend = 1'b0;
         end
      endcase
   end

   // (R11) outputs low under reset
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         state <= TUIRQ_IDLE;
         pend <= 1'b0;
         irq <= 1'b0;
      end
      else
      begin
         state <= next_state;
         pend <= next_pend;
         irq <= next_irq;
      end
   end

   assign irq_out = irq;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   pulse_single_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // (R11)
      irq_out |=> !irq_out)
      else $error("interrupt pulse longer than one cycle");
   event_edge_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // (R01)
      (event_in && state == TUIRQ_IDLE && !pend) |=> irq_out)
      else $error("idle event did not produce an edge");
   pend_served_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // (R01)
      event_in |-> ##[1:4] irq_out)
      else $error("event not signalled within four cycles");
endmodule : tuirq_edge

// *** hdl/tuirq_top.sv ***
/*
 * interrupt output stage of the translation control unit.
 * turns internal event strobes into edge interrupt wires, and for the
 * six message-capable sources instead into message requests for the
 * table-walk master port when message mode is selected.
 * assumes all event inputs are single-cycle strobes or levels from
 * logic on sys_clk_in; the message port answers with msi_ack_in.
 */
// Notes on behaviour
// (R01) every interrupt output gives a fresh rising edge per occurrence
// (R02) receiving controller detects rising edges, not held levels
// (R03) event queue interrupts raised when queue not empty or overflowed
// (R04) sync completion interrupt raised when a sync command finishes
// (R05) separate secure and non-secure global interrupt outputs
// (R06) queue, sync and global interrupts may go as messages instead
// (R07) integrator may leave a wire open when messages are captured
// (R08) reliability interrupt is wire only, never a message
// (R09) monitor interrupt is wire only, never a message
// (R10) page request queue interrupt output provided
// (R11) outputs low in and after reset, low again before each edge
`timescale 1ns/1ns
`include "tuirq_defs.svh"

module tuirq_top
(
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic secure_evtq_nonempty_in,
   input wire logic secure_evtq_overflow_in,
   input wire logic nonsecure_evtq_nonempty_in,
   input wire logic nonsecure_evtq_overflow_in,
   input wire logic secure_syncdone_in,
   input wire logic nonsecure_syncdone_in,
   input wire logic secure_global_in,
   input wire logic nonsecure_global_in,
   input wire logic ras_event_in,
   input wire logic pmu_event_in,
   input wire logic page_request_event_in,
   input wire logic [5:0] msi_enable_in,
   input wire logic msi_ack_in,
   output logic secure_evtq_irq_out,
   output logic nonsecure_evtq_irq_out,
   output logic secure_syncdone_irq_out,
   output logic nonsecure_syncdone_irq_out,
   output logic secure_global_irq_out,
   output logic nonsecure_global_irq_out,
   output logic ras_irq_out,
   output logic pmu_irq_out,
   output logic page_request_queue_irq_out,
   output logic msi_req_out,
   output logic [3:0] msi_src_out
);
   import tuirq_pkg::*;

   logic [`TUIRQ_NSRC-1:0] cond;
   logic [`TUIRQ_NSRC-1:0] cond_q;
   logic [`TUIRQ_NSRC-1:0] next_cond_q;
   logic [`TUIRQ_NSRC-1:0] occur;
   logic [`TUIRQ_NSRC-1:0] to_wire;
   logic [`TUIRQ_NSRC-1:0] irq;
   logic [5:0] to_msi;
   logic [5:0] msi_pend;
   logic [5:0] next_msi_pend;
   logic msi_req;
   logic next_msi_req;
   logic [3:0] msi_src;
   logic [3:0] next_msi_src;

   // -----------------------------------------------------------------
   // event conditions
   // -----------------------------------------------------------------
   // (R03) not empty or overflowed per queue
   always_comb
   begin
      cond = '0;
      cond[`TUIRQ_SRC_EVTQ_S] = secure_evtq_nonempty_in | secure_evtq_overflow_in;
      cond[`TUIRQ_SRC_EVTQ_NS] = nonsecure_evtq_nonempty_in | nonsecure_evtq_overflow_in;
      // (R04) sync completion per world
      cond[`TUIRQ_SRC_SYNC_S] = secure_syncdone_in;
      cond[`TUIRQ_SRC_SYNC_NS] = nonsecure_syncdone_in;
      // (R05) two separate global sources
      cond[`TUIRQ_SRC_GLOB_S] = secure_global_in;
      cond[`TUIRQ_SRC_GLOB_NS] = nonsecure_global_in;
      cond[`TUIRQ_SRC_RAS] = ras_event_in;
      cond[`TUIRQ_SRC_PMU] = pmu_event_in;
      // (R10) page request queue source
      cond[`TUIRQ_SRC_PRIQ] = page_request_event_in;
   end

   // a held condition counts once: only its rising edge is an occurrence,
   // so a queue that stays non-empty does not flood the controller
   always_comb
   begin
      next_cond_q = cond;
      occur = cond & ~cond_q;
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
         cond_q <= '0;
      else
         cond_q <= next_cond_q;
   end

   // -----------------------------------------------------------------
   // routing between wire and message
   // -----------------------------------------------------------------
   // (R06) message mode steals the occurrence from the wire
   // (R08) (R09) upper sources never take the message path
   always_comb
   begin
      to_msi = occur[5:0] & msi_enable_in;
      to_wire = occur & ~{3'h0, to_msi};
   end

   // (R01) one edge generator per source
   genvar g;
   generate
      for (g = 0; g < `TUIRQ_NSRC; g = g + 1)
      begin : gen_edge
         tuirq_edge u_edge
         (
            .sys_clk_in(sys_clk_in),
            .srst_in(srst_in),
            .event_in(to_wire[g]),
            .irq_out(irq[g])
         );
      end
   endgenerate

   // -----------------------------------------------------------------
   // message request: lowest pending source first, held until ack
   // -----------------------------------------------------------------
   always_comb
   begin
      next_msi_pend = msi_pend | to_msi;
      next_msi_req = msi_req;
      next_msi_src = msi_src;
      if (msi_req && msi_ack_in)
      begin
         next_msi_req = 1'b0;
         // set wins over clear for a same-cycle new occurrence
         next_msi_pend[msi_src[2:0]] = to_msi[msi_src[2:0]];
      end
      else if (!msi_req)
      begin
         for (int i = 5; i >= 0; i--)
         begin
            if (msi_pend[i])
            begin
               next_msi_req = 1'b1;
               next_msi_src = 4'(i);
            end
         end
      end
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         msi_pend <= '0;
         msi_req <= 1'b0;
         msi_src <= 4'h0;
      end
      else
      begin
         msi_pend <= next_msi_pend;
         msi_req <= next_msi_req;
         msi_src <= next_msi_src;
      end
   end

   // -----------------------------------------------------------------
   // outputs, each straight from a flip-flop
   // -----------------------------------------------------------------
   // (R07) unused wires simply stay low in message mode
   assign secure_evtq_irq_out = irq[`TUIRQ_SRC_EVTQ_S];
   assign nonsecure_evtq_irq_out = irq[`TUIRQ_SRC_EVTQ_NS];
   assign secure_syncdone_irq_out = irq[`TUIRQ_SRC_SYNC_S];
   assign nonsecure_syncdone_irq_out = irq[`TUIRQ_SRC_SYNC_NS];
   assign secure_global_irq_out = irq[`TUIRQ_SRC_GLOB_S];
   assign nonsecure_global_irq_out = irq[`TUIRQ_SRC_GLOB_NS];
   assign ras_irq_out = irq[`TUIRQ_SRC_RAS];
   assign pmu_irq_out = irq[`TUIRQ_SRC_PMU];
   assign page_request_queue_irq_out = irq[`TUIRQ_SRC_PRIQ];
   assign msi_req_out = msi_req;
   assign msi_src_out = msi_src;

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   sequence msi_raised_s;
      msi_req_out && !$past(msi_req_out);
   endsequence

   sequence msi_held_s;
      msi_req_out && $stable(msi_src_out);
   endsequence

   msi_src_legal_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // (R08)
      msi_req_out |-> msi_src_out < 4'h6)
      else $error("wire-only source sent as message");
   msi_hold_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // (R06)
      (msi_req_out && !msi_ack_in) |=> msi_held_s)
      else $error("message request dropped before ack");
   msi_start_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // (R06)
      msi_raised_s |-> $past(msi_pend) != 6'h0)
      else $error("message raised with nothing pending");
   ras_wire_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // (R08)
      (ras_event_in && !$past(ras_event_in)) |-> ##[1:5] ras_irq_out)
      else $error("reliability event missing on wire");
   pmu_wire_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // (R09)
      (pmu_event_in && !$past(pmu_event_in)) |-> ##[1:5] pmu_irq_out)
      else $error("monitor event missing on wire");
   evtq_wire_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // (R03)
      (occur[`TUIRQ_SRC_EVTQ_NS] && !msi_enable_in[`TUIRQ_SRC_EVTQ_NS])
      |-> ##[1:5] nonsecure_evtq_irq_out)
      else $error("non-secure event queue edge missing");
   sync_wire_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // (R04)
      (occur[`TUIRQ_SRC_SYNC_S] && !msi_enable_in[`TUIRQ_SRC_SYNC_S])
      |-> ##[1:5] secure_syncdone_irq_out)
      else $error("secure sync completion edge missing");
   priq_edge_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // (R10)
      page_request_queue_irq_out |=> !page_request_queue_irq_out)
      else $error("page request interrupt not returned low");
   global_sep_a: assert property (@(posedge sys_clk_in) disable iff (srst_in) // (R05)
      (occur[`TUIRQ_SRC_GLOB_S] && !occur[`TUIRQ_SRC_GLOB_NS] && !msi_req_out
       && $past(!nonsecure_global_irq_out) && !msi_enable_in[4]) |=> !nonsecure_global_irq_out)
      else $error("secure global raised non-secure wire");
   reset_low_a: assert property (@(posedge sys_clk_in) // (R11)
      $past(srst_in) |-> (irq == '0 && !msi_req_out))
      else $error("outputs not low after reset");
endmodule : tuirq_top

// *** verification/tuirq_ctrl_model.sv ***
/*
 * model of the system interrupt controller: captures rising edges of
 * the wires and accepts message requests after a random delay.
 * assumes the bench seeds $urandom and shares the design clock.
 */
`timescale 1ns/1ns
module tuirq_ctrl_model
(
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic [8:0] irq_in,
   input wire logic msi_req_in,
   output logic msi_ack_out,
   output logic [8:0] capture_out
);
   logic [8:0] prev = 9'h000;
   int dly = 0;
   initial msi_ack_out = 1'b0;
   initial capture_out = 9'h000;
   // ------------------------------------------------
   // wire capture
   // ------------------------------------------------
   // rising edge capture
   // a held level captures nothing, only a fresh 0 to 1 change
   always @(posedge sys_clk_in)
   begin
      prev <= srst_in ? 9'h000 : irq_in;
      capture_out <= srst_in ? 9'h000 : irq_in & ~prev;
   end
   // message capture
   // ack is one cycle wide, after 0..3 cycles so both prompt and slow
   always @(posedge sys_clk_in)
   begin
      #1;
      if (msi_ack_out)
         msi_ack_out = 1'b0;
      else if (msi_req_in && dly == 0)
      begin
         msi_ack_out = 1'b1;
         dly = $urandom_range(3, 0);
      end
      else if (msi_req_in)
         dly--;
   end
endmodule : tuirq_ctrl_model

// *** verification/tuirq_top_tb.sv ***
/*
 * self-checking bench for the interrupt output stage: notes each
 * expected wire or message in a queue and checks it as it appears.
 * assumes the design and the controller model are compiled before it.
 */
`timescale 1ns/1ns
module tuirq_top_tb;
   logic sys_clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic [10:0] cond = 11'h000;
   logic [5:0] msi_en = 6'h00;
   logic msi_ack;
   logic msi_req;
   logic [3:0] msi_src;
   logic [8:0] irq;
   logic [8:0] cap;
   logic [9:0] q[$];
   int err_count = 0;
   int compares = 0;
   int i;
   int j;
   always #2 sys_clk_in = ~sys_clk_in;
   tuirq_top dut
   (
      .sys_clk_in(sys_clk_in), .srst_in(srst_in),
      .secure_evtq_nonempty_in(cond[0]), .secure_evtq_overflow_in(cond[1]),
      .nonsecure_evtq_nonempty_in(cond[2]), .nonsecure_evtq_overflow_in(cond[3]),
      .secure_syncdone_in(cond[4]), .nonsecure_syncdone_in(cond[5]),
      .secure_global_in(cond[6]), .nonsecure_global_in(cond[7]),
      .ras_event_in(cond[8]), .pmu_event_in(cond[9]), .page_request_event_in(cond[10]),
      .msi_enable_in(msi_en), .msi_ack_in(msi_ack),
      .secure_evtq_irq_out(irq[0]), .nonsecure_evtq_irq_out(irq[1]),
      .secure_syncdone_irq_out(irq[2]), .nonsecure_syncdone_irq_out(irq[3]),
      .secure_global_irq_out(irq[4]), .nonsecure_global_irq_out(irq[5]),
      .ras_irq_out(irq[6]), .pmu_irq_out(irq[7]), .page_request_queue_irq_out(irq[8]),
      .msi_req_out(msi_req), .msi_src_out(msi_src)
   );
   tuirq_ctrl_model partner
   (
      .sys_clk_in(sys_clk_in), .srst_in(srst_in), .irq_in(irq),
      .msi_req_in(msi_req), .msi_ack_out(msi_ack), .capture_out(cap)
   );
   task check(input logic [9:0] seen, input logic [9:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task final_report;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report
   // one occurrence held as a level: it must give exactly one result
   task fire(input int src, input bit msg);
      int b;
      b = src < 2 ? 2 * src + $urandom_range(1, 0) : src + 2;
      @(posedge sys_clk_in);
      #1;
      cond[b] = 1'b1;
      q.push_back(msg ? 10'h010 + 10'(src) : 10'(src));
      repeat (8) @(posedge sys_clk_in);
      #1;
      cond[b] = 1'b0;
      repeat (4) @(posedge sys_clk_in);
      #1;
   endtask : fire
   // ------------------------------------------------
   // monitor: oldest note against each result seen
   // ------------------------------------------------
   always @(posedge sys_clk_in)
   begin
      for (int k = 0; k < 9; k++)
         if (cap[k] === 1'b1)
            check(10'(k), q.size() > 0 ? q.pop_front() : 10'h3ff);
      if (msi_req === 1'b1 && msi_ack === 1'b1)
         check({6'h01, msi_src}, q.size() > 0 ? q.pop_front() : 10'h3ff);
   end
   // watchdog: the tests need under 1000 cycles, this allows 5000
   initial
   begin
      #20000;
      err_count++;
      final_report();
   end
   initial
   begin
      void'($urandom(35));
      repeat (12) @(posedge sys_clk_in);
      #1;
      srst_in = 1'b0;
      for (i = 0; i < 9; i++)
         fire(i, 1'b0);
      $display("test all wires done");
      msi_en = 6'h3f;
      for (i = 0; i < 9; i++)
         fire(i, i < 6);
      $display("test all messages done");
      for (i = 0; i < 24; i++)
      begin
         msi_en = 6'($urandom());
         j = $urandom_range(8, 0);
         fire(j, j < 6 && msi_en[j % 6]);
      end
      $display("test random mix done");
      // close repeat on the monitor wire: two rises, two edges
      cond[9] = 1'b1;
      q.push_back(10'h007);
      repeat (2) @(posedge sys_clk_in);
      #1;
      cond[9] = 1'b0;
      repeat (2) @(posedge sys_clk_in);
      #1;
      cond[9] = 1'b1;
      q.push_back(10'h007);
      repeat (8) @(posedge sys_clk_in);
      #1;
      cond[9] = 1'b0;
      repeat (4) @(posedge sys_clk_in);
      $display("test close repeat done");
      // mid-run reset with every condition raised: all stay low
      #1;
      srst_in = 1'b1;
      cond = 11'h7ff;
      repeat (3) @(posedge sys_clk_in);
      #1;
      check({irq, msi_req}, 10'h000);
      cond = 11'h000;
      repeat (2) @(posedge sys_clk_in);
      #1;
      srst_in = 1'b0;
      repeat (8) @(posedge sys_clk_in);
      #1;
      check(10'(q.size()), 10'h000);
      $display("test reset done");
      final_report();
   end
endmodule : tuirq_top_tb
